/* File: src/ptsm_port_monitor.sv */
// port traffic statistics and congestion monitor, one serial port
//
// Functional notes
// [R1] one complete independent monitor instance exists per serial port.
// [R2] a statistics counter can count each 32-bit word sent or received.
// [R3] a statistics counter can count each packet sent or received.
// [R4] a statistics counter can count packets of one priority 0..3 only.
// [R5] retried packets never advance packet-based statistics counters.
// [R6] each direction has a programmable queue depth watermark compared to depth.
// [R7] each direction counts separate occasions the depth rises above watermark.
// [R8] each direction accumulates time above watermark at selectable resolution.
// [R9] exceed count passing a limit can raise interrupt, port-write, or both.
// [R10] a counter counts packets reordered for lack of fabric progress.
// [R11] an interrupt is raised when the reorder count reaches its threshold.
// [R12] all monitoring counters accept software writes as well as reads.
// [R13] a read returns the counter value and then clears it.
// [R14] counters saturate at maximum instead of wrapping.
// [R15] an event coinciding with a clearing read leaves the counter at one.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module ptsm_port_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ptsm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ptsm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ptsm_pkg::DATA_W-1:0] rdata_o,
  input wire logic tx_word_i,
  input wire logic tx_pkt_i,
  input wire logic [ptsm_pkg::PRIO_W-1:0] tx_prio_i,
  input wire logic tx_retry_i,
  input wire logic [ptsm_pkg::DEPTH_W-1:0] tx_depth_i,
  input wire logic rx_word_i,
  input wire logic rx_pkt_i,
  input wire logic [ptsm_pkg::PRIO_W-1:0] rx_prio_i,
  input wire logic rx_retry_i,
  input wire logic [ptsm_pkg::DEPTH_W-1:0] rx_depth_i,
  input wire logic reorder_i,
  output logic irq_o,
  output logic port_write_o,
  output logic [ptsm_pkg::N_DIR-1:0] port_write_src_o
);
  // configuration registers
  logic [ptsm_pkg::DATA_W-1:0] cnt_cfg;
  logic [ptsm_pkg::DATA_W-1:0] next_cnt_cfg;
  logic [ptsm_pkg::DEPTH_W-1:0] wm [ptsm_pkg::N_DIR];
  logic [ptsm_pkg::DEPTH_W-1:0] next_wm [ptsm_pkg::N_DIR];
  logic [ptsm_pkg::DATA_W-1:0] lim [ptsm_pkg::N_DIR];
  logic [ptsm_pkg::DATA_W-1:0] next_lim [ptsm_pkg::N_DIR];
  logic [ptsm_pkg::SEL_W-1:0] tbase;
  logic [ptsm_pkg::SEL_W-1:0] next_tbase;
  logic [ptsm_pkg::DATA_W-1:0] reord_thr;
  logic [ptsm_pkg::DATA_W-1:0] next_reord_thr;
  logic [ptsm_pkg::IRQ_W-1:0] irq_mask;
  logic [ptsm_pkg::IRQ_W-1:0] next_irq_mask;
  logic [ptsm_pkg::N_DIR-1:0] pw_en;
  logic [ptsm_pkg::N_DIR-1:0] next_pw_en;

  // status, notification and read data
  logic [ptsm_pkg::IRQ_W-1:0] irq_stat;
  logic [ptsm_pkg::IRQ_W-1:0] next_irq_stat;
  logic [ptsm_pkg::IRQ_W-1:0] irq_evt;
  logic pw;
  logic next_pw;
  logic [ptsm_pkg::N_DIR-1:0] pw_src;
  logic [ptsm_pkg::N_DIR-1:0] next_pw_src;
  logic [ptsm_pkg::DATA_W-1:0] rdata;
  logic [ptsm_pkg::DATA_W-1:0] next_rdata;

  // watermark tracking and time base
  logic [ptsm_pkg::N_DIR-1:0] above;
  logic [ptsm_pkg::N_DIR-1:0] next_above;
  logic [ptsm_pkg::N_DIR-1:0] above_now;
  logic [ptsm_pkg::N_DIR-1:0] wm_pass;
  logic [ptsm_pkg::PRESC_W-1:0] presc;
  logic [ptsm_pkg::PRESC_W-1:0] next_presc;
  logic [ptsm_pkg::PRESC_W-1:0] presc_mask;
  logic tick;

  // counter bank
  logic [ptsm_pkg::N_CNT-1:0] cnt_inc;
  logic [ptsm_pkg::N_CNT-1:0] cnt_clr;
  logic [ptsm_pkg::N_CNT-1:0] cnt_wr;
  logic [ptsm_pkg::DATA_W-1:0] cnt_q [ptsm_pkg::N_CNT];
  logic [ptsm_pkg::DATA_W-1:0] cnt_next [ptsm_pkg::N_CNT];

  // per-direction traffic views
  logic [ptsm_pkg::N_DIR-1:0] word_ev;
  logic [ptsm_pkg::N_DIR-1:0] good_pkt;
  logic [ptsm_pkg::PRIO_W-1:0] pkt_prio [ptsm_pkg::N_DIR];
  logic [ptsm_pkg::DEPTH_W-1:0] depth [ptsm_pkg::N_DIR];

  always_comb begin
    word_ev = {rx_word_i, tx_word_i};
    good_pkt[ptsm_pkg::DIR_TX] = tx_pkt_i && !tx_retry_i; // [R5]
    good_pkt[ptsm_pkg::DIR_RX] = rx_pkt_i && !rx_retry_i; // [R5]
    pkt_prio[ptsm_pkg::DIR_TX] = tx_prio_i;
    pkt_prio[ptsm_pkg::DIR_RX] = rx_prio_i;
    depth[ptsm_pkg::DIR_TX] = tx_depth_i;
    depth[ptsm_pkg::DIR_RX] = rx_depth_i;
  end

  // configuration writes
  always_comb begin
    next_cnt_cfg = cnt_cfg;
    next_wm = wm;
    next_lim = lim;
    next_tbase = tbase;
    next_reord_thr = reord_thr;
    next_irq_mask = irq_mask;
    next_pw_en = pw_en;
    if (wr_i) begin
      unique case (addr_i)
        ptsm_pkg::A_CNT_CFG: begin
          next_cnt_cfg = wdata_i;
        end
        ptsm_pkg::A_TX_WM: begin
          next_wm[ptsm_pkg::DIR_TX] = wdata_i[ptsm_pkg::DEPTH_W-1:0]; // [R6]
        end
        ptsm_pkg::A_RX_WM: begin
          next_wm[ptsm_pkg::DIR_RX] = wdata_i[ptsm_pkg::DEPTH_W-1:0]; // [R6]
        end
        ptsm_pkg::A_TX_LIM: begin
          next_lim[ptsm_pkg::DIR_TX] = wdata_i;
        end
        ptsm_pkg::A_RX_LIM: begin
          next_lim[ptsm_pkg::DIR_RX] = wdata_i;
        end
        ptsm_pkg::A_TBASE: begin
          next_tbase = wdata_i[ptsm_pkg::SEL_W-1:0];
        end
        ptsm_pkg::A_REORD_THR: begin
          next_reord_thr = wdata_i;
        end
        ptsm_pkg::A_IRQ_MASK: begin
          next_irq_mask = wdata_i[ptsm_pkg::IRQ_W-1:0];
        end
        ptsm_pkg::A_PW_EN: begin
          next_pw_en = wdata_i[ptsm_pkg::N_DIR-1:0];
        end
        default: begin
          next_cnt_cfg = cnt_cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_cfg <= '0;
      wm[ptsm_pkg::DIR_TX] <= ptsm_pkg::RST_WM;
      wm[ptsm_pkg::DIR_RX] <= ptsm_pkg::RST_WM;
      lim[ptsm_pkg::DIR_TX] <= ptsm_pkg::RST_LIM;
      lim[ptsm_pkg::DIR_RX] <= ptsm_pkg::RST_LIM;
      tbase <= '0;
      reord_thr <= ptsm_pkg::RST_THR;
      irq_mask <= '0;
      pw_en <= '0;
    end else begin
      cnt_cfg <= next_cnt_cfg;
      wm <= next_wm;
      lim <= next_lim;
      tbase <= next_tbase;
      reord_thr <= next_reord_thr;
      irq_mask <= next_irq_mask;
      pw_en <= next_pw_en;
    end
  end

  // time base for congestion period resolution
  always_comb begin
    presc_mask = ~(16'hffff << tbase);
    tick = (presc & presc_mask) == presc_mask; // [R8]
    next_presc = presc + 16'h0001;
    for (int d = 0; d < ptsm_pkg::N_DIR; d++) begin
      above_now[d] = depth[d] > wm[d]; // [R6]
    end
    next_above = above_now;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      presc <= '0;
      above <= '0;
    end else begin
      presc <= next_presc;
      above <= next_above;
    end
  end

  // counter increments, clears and writes
  always_comb begin
    logic [ptsm_pkg::CFG_W-1:0] cfg;
    logic dir;
    ptsm_pkg::ptsm_mode_t mode;
    cfg = '0;
    dir = 1'b0;
    mode = ptsm_pkg::MODE_OFF;
    cnt_inc = '0;
    for (int s = 0; s < ptsm_pkg::N_STAT; s++) begin
      cfg = cnt_cfg[s*ptsm_pkg::CFG_STRIDE +: ptsm_pkg::CFG_W];
      dir = cfg[ptsm_pkg::CFG_DIR_BIT];
      mode = ptsm_pkg::ptsm_mode_t'(cfg[ptsm_pkg::CFG_MODE_LSB +: 2]);
      unique case (mode)
        ptsm_pkg::MODE_OFF: begin
          cnt_inc[s] = 1'b0;
        end
        ptsm_pkg::MODE_WORDS: begin
          cnt_inc[s] = word_ev[dir]; // [R2]
        end
        ptsm_pkg::MODE_PKTS: begin
          cnt_inc[s] = good_pkt[dir]; // [R3]
        end
        ptsm_pkg::MODE_PRIO: begin
          cnt_inc[s] = good_pkt[dir] &&
            pkt_prio[dir] ==
            cfg[ptsm_pkg::CFG_PRIO_LSB +: ptsm_pkg::PRIO_W]; // [R4]
        end
      endcase
    end
    cnt_inc[ptsm_pkg::C_TX_EXC] = above_now[ptsm_pkg::DIR_TX] &&
      !above[ptsm_pkg::DIR_TX]; // [R7]
    cnt_inc[ptsm_pkg::C_RX_EXC] = above_now[ptsm_pkg::DIR_RX] &&
      !above[ptsm_pkg::DIR_RX]; // [R7]
    cnt_inc[ptsm_pkg::C_TX_PER] = above_now[ptsm_pkg::DIR_TX] && tick; // [R8]
    cnt_inc[ptsm_pkg::C_RX_PER] = above_now[ptsm_pkg::DIR_RX] && tick; // [R8]
    cnt_inc[ptsm_pkg::C_REORD] = reorder_i; // [R10]
    for (int c = 0; c < ptsm_pkg::N_CNT; c++) begin
      cnt_clr[c] = rd_i &&
        addr_i == ptsm_pkg::CNT_ADDR[c*ptsm_pkg::ADDR_W +: ptsm_pkg::ADDR_W];
      cnt_wr[c] = wr_i &&
        addr_i == ptsm_pkg::CNT_ADDR[c*ptsm_pkg::ADDR_W +: ptsm_pkg::ADDR_W];
    end
  end

  // one counter per slot, the whole bank per port instance
  for (genvar g = 0; g < ptsm_pkg::N_CNT; g++) begin : g_cnt // [R1]
    ptsm_sat_cnt u_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .inc_i(cnt_inc[g]),
      .clr_i(cnt_clr[g]),
      .wr_i(cnt_wr[g]),
      .wdata_i(wdata_i),
      .q_o(cnt_q[g]),
      .next_o(cnt_next[g])
    );
  end

  // threshold events
  always_comb begin
    wm_pass[ptsm_pkg::DIR_TX] = cnt_next[ptsm_pkg::C_TX_EXC] >
      lim[ptsm_pkg::DIR_TX] &&
      !(cnt_q[ptsm_pkg::C_TX_EXC] > lim[ptsm_pkg::DIR_TX]); // [R9]
    wm_pass[ptsm_pkg::DIR_RX] = cnt_next[ptsm_pkg::C_RX_EXC] >
      lim[ptsm_pkg::DIR_RX] &&
      !(cnt_q[ptsm_pkg::C_RX_EXC] > lim[ptsm_pkg::DIR_RX]); // [R9]
    irq_evt = '0;
    irq_evt[ptsm_pkg::IRQ_TX_WM] = wm_pass[ptsm_pkg::DIR_TX];
    irq_evt[ptsm_pkg::IRQ_RX_WM] = wm_pass[ptsm_pkg::DIR_RX];
    irq_evt[ptsm_pkg::IRQ_REORD] = reord_thr != '0 &&
      cnt_next[ptsm_pkg::C_REORD] == reord_thr &&
      cnt_q[ptsm_pkg::C_REORD] != reord_thr; // [R11]
  end

  // sticky status, port-write request, read data
  always_comb begin
    next_irq_stat = irq_stat;
    if (rd_i && addr_i == ptsm_pkg::A_IRQ_STAT) begin
      next_irq_stat = '0;
    end
    next_irq_stat = next_irq_stat | irq_evt;
    next_pw_src = wm_pass & pw_en; // [R9]
    next_pw = |next_pw_src; // [R9]
    next_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        ptsm_pkg::A_CNT_CFG: begin
          next_rdata = cnt_cfg;
        end
        ptsm_pkg::A_STAT0: begin
          next_rdata = cnt_q[ptsm_pkg::C_STAT0]; // [R13]
        end
        ptsm_pkg::A_STAT1: begin
          next_rdata = cnt_q[ptsm_pkg::C_STAT1]; // [R13]
        end
        ptsm_pkg::A_TX_WM: begin
          next_rdata = {24'h000000, wm[ptsm_pkg::DIR_TX]};
        end
        ptsm_pkg::A_RX_WM: begin
          next_rdata = {24'h000000, wm[ptsm_pkg::DIR_RX]};
        end
        ptsm_pkg::A_TX_LIM: begin
          next_rdata = lim[ptsm_pkg::DIR_TX];
        end
        ptsm_pkg::A_RX_LIM: begin
          next_rdata = lim[ptsm_pkg::DIR_RX];
        end
        ptsm_pkg::A_TX_EXC: begin
          next_rdata = cnt_q[ptsm_pkg::C_TX_EXC]; // [R13]
        end
        ptsm_pkg::A_RX_EXC: begin
          next_rdata = cnt_q[ptsm_pkg::C_RX_EXC]; // [R13]
        end
        ptsm_pkg::A_TX_PER: begin
          next_rdata = cnt_q[ptsm_pkg::C_TX_PER]; // [R13]
        end
        ptsm_pkg::A_RX_PER: begin
          next_rdata = cnt_q[ptsm_pkg::C_RX_PER]; // [R13]
        end
        ptsm_pkg::A_TBASE: begin
          next_rdata = {28'h0000000, tbase};
        end
        ptsm_pkg::A_REORD: begin
          next_rdata = cnt_q[ptsm_pkg::C_REORD]; // [R13]
        end
        ptsm_pkg::A_REORD_THR: begin
          next_rdata = reord_thr;
        end
        ptsm_pkg::A_IRQ_STAT: begin
          next_rdata = {29'h00000000, irq_stat};
        end
        ptsm_pkg::A_IRQ_MASK: begin
          next_rdata = {29'h00000000, irq_mask};
        end
        ptsm_pkg::A_PW_EN: begin
          next_rdata = {30'h00000000, pw_en};
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat <= '0;
      pw <= 1'b0;
      pw_src <= '0;
      rdata <= '0;
    end else begin
      irq_stat <= next_irq_stat;
      pw <= next_pw;
      pw_src <= next_pw_src;
      rdata <= next_rdata;
    end
  end

  assign irq_o = |(irq_stat & irq_mask); // [R9] [R11]
  assign port_write_o = pw;
  assign port_write_src_o = pw_src;
  assign rdata_o = rdata;
endmodule

/* File: include/ptsm_pkg.sv */
// port traffic statistics monitor: shared constants and types
package ptsm_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int DEPTH_W = 8;
  localparam int PRESC_W = 16;
  localparam int SEL_W = 4;
  localparam int PRIO_W = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] A_CNT_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] A_STAT0 = 8'h04;
  localparam logic [ADDR_W-1:0] A_STAT1 = 8'h08;
  localparam logic [ADDR_W-1:0] A_TX_WM = 8'h0c;
  localparam logic [ADDR_W-1:0] A_TX_LIM = 8'h10;
  localparam logic [ADDR_W-1:0] A_TX_EXC = 8'h14;
  localparam logic [ADDR_W-1:0] A_TX_PER = 8'h18;
  localparam logic [ADDR_W-1:0] A_RX_WM = 8'h1c;
  localparam logic [ADDR_W-1:0] A_RX_LIM = 8'h20;
  localparam logic [ADDR_W-1:0] A_RX_EXC = 8'h24;
  localparam logic [ADDR_W-1:0] A_RX_PER = 8'h28;
  localparam logic [ADDR_W-1:0] A_TBASE = 8'h2c;
  localparam logic [ADDR_W-1:0] A_REORD = 8'h30;
  localparam logic [ADDR_W-1:0] A_REORD_THR = 8'h34;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h38;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h3c;
  localparam logic [ADDR_W-1:0] A_PW_EN = 8'h40;

  // counter slots
  localparam int C_STAT0 = 0;
  localparam int C_STAT1 = 1;
  localparam int C_TX_EXC = 2;
  localparam int C_TX_PER = 3;
  localparam int C_RX_EXC = 4;
  localparam int C_RX_PER = 5;
  localparam int C_REORD = 6;
  localparam int N_CNT = 7;
  localparam int N_STAT = 2;
  localparam logic [N_CNT*ADDR_W-1:0] CNT_ADDR = {A_REORD, A_RX_PER,
    A_RX_EXC, A_TX_PER, A_TX_EXC, A_STAT1, A_STAT0};

  // statistics counter configuration fields
  localparam int CFG_STRIDE = 8;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DIR_BIT = 2;
  localparam int CFG_PRIO_LSB = 3;
  localparam int CFG_W = 5;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_WORDS,
    MODE_PKTS,
    MODE_PRIO
  } ptsm_mode_t;

  // interrupt status bits
  localparam int IRQ_TX_WM = 0;
  localparam int IRQ_RX_WM = 1;
  localparam int IRQ_REORD = 2;
  localparam int IRQ_W = 3;

  // port-write enable bits, direction index 0 tx, 1 rx
  localparam int DIR_TX = 0;
  localparam int DIR_RX = 1;
  localparam int N_DIR = 2;

  // reset values and counter saturation maximum
  localparam logic [DEPTH_W-1:0] RST_WM = 8'hff;
  localparam logic [DATA_W-1:0] RST_LIM = 32'hffffffff;
  localparam logic [DATA_W-1:0] RST_THR = 32'h00000000;
  localparam logic [DATA_W-1:0] CNT_MAX = 32'hffffffff;
endpackage

/* File: src/ptsm_sat_cnt.sv */
// saturating, writable, clear-on-read counter
`timescale 1ns/1ps
module ptsm_sat_cnt (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic inc_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [ptsm_pkg::DATA_W-1:0] wdata_i,
  output logic [ptsm_pkg::DATA_W-1:0] q_o,
  output logic [ptsm_pkg::DATA_W-1:0] next_o
);
  logic [ptsm_pkg::DATA_W-1:0] q;
  logic [ptsm_pkg::DATA_W-1:0] next_q;
  logic [ptsm_pkg::DATA_W-1:0] base;

  always_comb begin
    base = q;
    if (clr_i) begin
      base = '0; // [R13]
    end else if (wr_i) begin
      base = wdata_i; // [R12]
    end
    next_q = base;
    if (inc_i && base != ptsm_pkg::CNT_MAX) begin // [R14]
      next_q = base + 32'h00000001; // [R15]
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q;
  assign next_o = next_q;
endmodule

/* File: bench/ptsm_port_monitor_sva.sv */
// assertion checker for the port traffic statistics monitor
`timescale 1ns/1ps
module ptsm_port_monitor_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ptsm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ptsm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ptsm_pkg::DATA_W-1:0] rdata_o,
  input wire logic reorder_i,
  input wire logic irq_o,
  input wire logic port_write_o,
  input wire logic [ptsm_pkg::N_DIR-1:0] port_write_src_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  property p_rd_idle;
    !rd_i |=> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle data");

  property p_unmapped;
    rd_i && (addr_i > ptsm_pkg::A_PW_EN || addr_i[1:0] != 2'h0)
      |=> rdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");

  property p_reord_clr;
    rd_i && addr_i == ptsm_pkg::A_REORD && !reorder_i
      ##1 rd_i && addr_i == ptsm_pkg::A_REORD |=> rdata_o == '0;
  endproperty
  a_reord_clr: assert property (p_reord_clr) else $error("no clear");

  property p_clr_event;
    rd_i && addr_i == ptsm_pkg::A_REORD && reorder_i
      ##1 rd_i && addr_i == ptsm_pkg::A_REORD |=> rdata_o == 32'h1;
  endproperty
  a_clr_event: assert property (p_clr_event) else $error("lost");

  property p_wr_rd;
    wr_i && addr_i == ptsm_pkg::A_TX_WM ##1 !wr_i && !rd_i
      ##1 rd_i && addr_i == ptsm_pkg::A_TX_WM
      |=> rdata_o == {24'h0, $past(wdata_i[7:0], 3)};
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("watermark");

  property p_irq_mask;
    irq_o && rd_i && addr_i == ptsm_pkg::A_IRQ_MASK |=> rdata_o != '0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq mask");

  property p_pw_src;
    port_write_o |-> port_write_src_o != '0;
  endproperty
  a_pw_src: assert property (p_pw_src) else $error("pw source");

  property p_pw_one;
    port_write_o && port_write_src_o[0]
      |=> !(port_write_o && port_write_src_o[0]);
  endproperty
  a_pw_one: assert property (p_pw_one) else $error("pw twice");

  property p_cfg_hold;
    rd_i && addr_i == ptsm_pkg::A_CNT_CFG
      ##1 rd_i && addr_i == ptsm_pkg::A_CNT_CFG |=> $stable(rdata_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config");
endmodule

bind ptsm_port_monitor ptsm_port_monitor_sva ptsm_port_monitor_sva_inst (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reorder_i(reorder_i),
  .irq_o(irq_o), .port_write_o(port_write_o),
  .port_write_src_o(port_write_src_o)
);

/* File: bench/ptsm_queue_model.sv */
// model of the port transmit and receive queues
`timescale 1ns/1ps
module ptsm_queue_model (
  input wire logic clk_i,
  output logic [1:0] word_o,
  output logic [1:0] pkt_o,
  output logic [1:0] retry_o,
  output logic [3:0] prio_o,
  output logic [15:0] depth_o,
  output logic reorder_o
);
  initial {word_o, pkt_o, retry_o, prio_o, depth_o, reorder_o} = '0;

  // words of one packet, packet marker on the last word
  task automatic pkt(input int d, input logic [1:0] p, input logic r,
      input int n);
    for (int i = 1; i <= n; i++) begin
      word_o[d] <= 1'b1;
      pkt_o[d] <= 1'(i == n);
      prio_o[2*d +: 2] <= (i == n) ? p : ~p;
      retry_o[d] <= (i == n) ? r : ~r;
      @(posedge clk_i);
    end
    word_o[d] <= 1'b0;
    pkt_o[d] <= 1'b0;
    prio_o[2*d +: 2] <= ~p;
    retry_o[d] <= ~r;
    @(posedge clk_i);
  endtask

  task automatic dep(input int d, input logic [7:0] v, input int n);
    depth_o[8*d +: 8] <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic reord(input int n);
    repeat (n) begin
      reorder_o <= 1'b1;
      @(posedge clk_i);
    end
    reorder_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking testbench for the port traffic statistics monitor
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [1:0] word;
  logic [1:0] pkt;
  logic [1:0] retry;
  logic [3:0] prio;
  logic [15:0] depth;
  logic reorder;
  logic irq_o;
  logic port_write_o;
  logic [1:0] port_write_src_o;
  logic [1:0] pw_src;
  logic [7:0] o;
  int errors = 0;
  int samples_checked = 0;
  int pw_cnt = 0;
  int pw_base = 0;

  always #12.5 clk_i = ~clk_i;

  ptsm_port_monitor ptsm_port_monitor_inst (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_word_i(word[0]),
    .tx_pkt_i(pkt[0]), .tx_prio_i(prio[1:0]), .tx_retry_i(retry[0]),
    .tx_depth_i(depth[7:0]), .rx_word_i(word[1]), .rx_pkt_i(pkt[1]),
    .rx_prio_i(prio[3:2]), .rx_retry_i(retry[1]),
    .rx_depth_i(depth[15:8]), .reorder_i(reorder), .irq_o(irq_o),
    .port_write_o(port_write_o), .port_write_src_o(port_write_src_o)
  );

  ptsm_queue_model q (
    .clk_i(clk_i), .word_o(word), .pkt_o(pkt), .retry_o(retry),
    .prio_o(prio), .depth_o(depth), .reorder_o(reorder)
  );

  always @(negedge clk_i) begin
    if (port_write_o === 1'b1) begin
      pw_cnt++;
      pw_src = port_write_src_o;
    end
  end

  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // two back-to-back reads of one address
  task automatic rd(input logic [7:0] a, input logic [31:0] e1,
      input logic [31:0] e2);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk($sformatf("reg %h", a), e1, rdata_o);
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk($sformatf("reg %h again", a), e2, rdata_o);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, '0, '0);
    rd(8'h1c, 32'h0000_00ff, 32'h0000_00ff);
    rd(8'h20, 32'hffff_ffff, 32'hffff_ffff);
    rd(8'h34, '0, '0);
    rd(8'h44, '0, '0);
    rd(8'h06, '0, '0);
    q.pkt(0, 2'h0, 1'b0, 1);
    rd(8'h04, '0, '0);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, {16'h0, 8'h02, 3'h0, 2'(p), 3'h3});
      q.pkt(0, 2'(p), 1'b0, 2);
      q.pkt(0, 2'(p) ^ 2'h1, 1'b0, 1);
      q.pkt(0, 2'(p), 1'b1, 1);
      q.pkt(1, 2'(p), 1'b0, 1);
      rd(8'h04, 32'h1, '0);
      rd(8'h08, 32'h2, '0);
    end
    wr(8'h00, 32'h0000_0501);
    q.pkt(0, 2'h0, 1'b1, 3);
    q.pkt(1, 2'h0, 1'b0, 2);
    rd(8'h04, 32'h3, '0);
    rd(8'h08, 32'h2, '0);
    wr(8'h04, 32'hffff_fffe);
    q.pkt(0, 2'h0, 1'b0, 3);
    rd(8'h04, 32'hffff_ffff, '0);
    wr(8'h2c, 32'h1);
    for (int d = 0; d < 2; d++) begin
      o = 8'(16 * d);
      wr(8'h0c + o, 32'h3);
      rd(8'h0c + o, 32'h3, 32'h3);
      wr(8'h10 + o, '0);
      wr(8'h3c, 32'(1 << d));
      wr(8'h40, 32'(1 << d));
      pw_base = pw_cnt;
      q.dep(d, 8'h04, 4);
      q.dep(d, 8'h03, 2);
      q.dep(d, 8'h05, 2);
      q.dep(d, 8'h00, 2);
      chk_irq(1'b1);
      rd(8'h38, 32'(1 << d), '0);
      chk_irq(1'b0);
      rd(8'h14 + o, 32'h2, '0);
      rd(8'h18 + o, 32'h3, '0);
      chk("pw count", 32'h1, 32'(pw_cnt - pw_base));
      chk("pw source", 32'(1 << d), {30'h0, pw_src});
    end
    wr(8'h3c, '0);
    wr(8'h34, 32'h3);
    q.reord(3);
    chk_irq(1'b0);
    rd(8'h38, 32'h4, '0);
    fork
      q.reord(1);
      rd(8'h30, 32'h3, 32'h1);
    join
    wr(8'h3c, 32'h4);
    wr(8'h30, 32'h1);
    q.reord(2);
    chk_irq(1'b1);
    rd(8'h3c, 32'h4, 32'h4);
    rd(8'h30, 32'h3, '0);
    rd(8'h38, 32'h4, '0);
    chk_irq(1'b0);
    complete_run();
  end
endmodule
